// ---- inc/chopper_pkg.sv ----
package chopper_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] RISE_DELAY_OFFSET = 12'h000;
  localparam logic [11:0] FALL_DELAY_OFFSET = 12'h004;
  localparam logic [11:0] CHOPPER_CTRL_OFFSET = 12'h008;
  localparam logic [11:0] DEADBAND_MODE_OFFSET = 12'h00C;

  localparam int DELAY_W = 10;
  localparam logic [15:0] RISE_DELAY_RESET = 16'h0000;
  localparam logic [15:0] FALL_DELAY_RESET = 16'h0000;
  localparam logic [15:0] CHOPPER_CTRL_RESET = 16'h0000;
  localparam logic [1:0] DEADBAND_MODE_RESET = 2'h0;

  // ----------------------------------------
  // chopper control field positions
  // ----------------------------------------
  localparam int CHOP_EN_BIT = 0;
  localparam int PULSE_W_LO = 1;
  localparam int PULSE_W_HI = 4;
  localparam int FREQ_LO = 5;
  localparam int FREQ_HI = 7;
  localparam int DUTY_LO = 8;
  localparam int DUTY_HI = 10;
  localparam int CTRL_USED_HI = 10;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_RATE_MHZ = 100;
  localparam int BASE_DIV = 8;
  localparam logic [2:0] BASE_DIV_LAST = 3'(BASE_DIV - 1);
  localparam logic [2:0] DUTY_RESERVED = 3'h7;
  localparam logic [1:0] DB_BYPASS_BOTH = 2'h0;

  typedef struct packed {
    logic [2:0] carrier_duty_sel;
    logic [2:0] carrier_freq_sel;
    logic [3:0] first_pulse_width;
    logic chopping_on;
  } chop_cfg_t;

  typedef struct packed {
    logic a;
    logic b;
  } pwm_pair_t;

endpackage

// ---- logic/pwm_chopper.sv ----
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module pwm_chopper
  import chopper_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pwm_pair_t qual_in,
  input wire pwm_pair_t deadband_in,
  output logic [DELAY_W-1:0] rise_delay_count,
  output logic [DELAY_W-1:0] fall_delay_count,
  output logic pwm_out_a,
  output logic pwm_out_b
);

  // ----------------------------------------
  // apb register file
  // ----------------------------------------
  logic [DELAY_W-1:0] rise_delay_reg;
  logic [DELAY_W-1:0] fall_delay_reg;
  chop_cfg_t chopper_ctrl_reg;
  logic [1:0] db_mode_reg;

  // one address decode shared by every register select
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  wire wr_en = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire hit_rise = addr_is(paddr, RISE_DELAY_OFFSET);
  wire hit_fall = addr_is(paddr, FALL_DELAY_OFFSET);
  wire hit_ctrl = addr_is(paddr, CHOPPER_CTRL_OFFSET);
  wire hit_mode = addr_is(paddr, DEADBAND_MODE_OFFSET);
  wire hit_any = hit_rise | hit_fall | hit_ctrl | hit_mode;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_delay_reg <= RISE_DELAY_RESET[DELAY_W-1:0];
    end else if (wr_en && hit_rise) begin
      rise_delay_reg <= pwdata[DELAY_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_delay_reg <= FALL_DELAY_RESET[DELAY_W-1:0];
    end else if (wr_en && hit_fall) begin
      fall_delay_reg <= pwdata[DELAY_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chopper_ctrl_reg <= CHOPPER_CTRL_RESET[CTRL_USED_HI:0];
    end else if (wr_en && hit_ctrl) begin
      chopper_ctrl_reg <= pwdata[CTRL_USED_HI:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_mode_reg <= DEADBAND_MODE_RESET;
    end else if (wr_en && hit_mode) begin
      db_mode_reg <= pwdata[1:0];
    end
  end

  // reserved bits read as zero
  wire [31:0] rd_rise = {22'h0, rise_delay_reg};
  wire [31:0] rd_fall = {22'h0, fall_delay_reg};
  wire [31:0] rd_ctrl = {21'h0, chopper_ctrl_reg};
  wire [31:0] rd_mode = {30'h0, db_mode_reg};

  wire [31:0] rd_word = hit_rise ? rd_rise :
                        hit_fall ? rd_fall :
                        hit_ctrl ? rd_ctrl :
                        hit_mode ? rd_mode : 32'h0;

  // captured in the setup phase so the word stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rd_word;
    end
  end

  assign rise_delay_count = rise_delay_reg;
  assign fall_delay_count = fall_delay_reg;

  // ----------------------------------------
  // input select
  // ----------------------------------------
  pwm_pair_t chop_in;
  assign chop_in = (db_mode_reg == DB_BYPASS_BOTH) ? qual_in : deadband_in;

  // ----------------------------------------
  // clock/8 base tick
  // ----------------------------------------
  logic [2:0] base_cnt_reg;
  wire base_tick = (base_cnt_reg == BASE_DIV_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) base_cnt_reg <= 3'h0;
    else base_cnt_reg <= base_cnt_reg + 3'h1;
  end

  // ----------------------------------------
  // carrier: 8 slots per period, each slot lasts (freq+1) clocks,
  // so one period is the clock divided by 8 and then by (freq+1)
  // ----------------------------------------
  logic [2:0] pre_cnt_reg;
  logic [2:0] pre_cnt_next;
  logic [2:0] slot_reg;
  logic [2:0] slot_next;
  wire pre_last = (pre_cnt_reg == chopper_ctrl_reg.carrier_freq_sel);

  // a smaller code written mid-count must not leave the prescaler above it
  wire pre_wrap = pre_last | (pre_cnt_reg > chopper_ctrl_reg.carrier_freq_sel);
  assign pre_cnt_next = pre_wrap ? 3'h0 : pre_cnt_reg + 3'h1;
  assign slot_next = pre_wrap ? slot_reg + 3'h1 : slot_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= 3'h0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_reg <= 3'h0;
    end else begin
      slot_reg <= slot_next;
    end
  end

  // reserved duty code keeps the carrier low rather than guessing a duty
  wire carrier = (chopper_ctrl_reg.carrier_duty_sel != DUTY_RESERVED) &&
                 (slot_reg <= chopper_ctrl_reg.carrier_duty_sel);

  // ----------------------------------------
  // per-channel one-shot and gating
  // ----------------------------------------
  logic [1:0] in_bits;
  wire [1:0] chopped;
  wire [1:0] out_next;
  assign in_bits = {chop_in.a, chop_in.b};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic prev_reg;
      logic shot_reg;
      logic [3:0] shot_cnt_reg;
      wire rise = in_bits[g] & ~prev_reg;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_reg <= 1'b0;
        end else begin
          prev_reg <= in_bits[g];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shot_reg <= 1'b0;
          shot_cnt_reg <= 4'h0;
        end else begin
          if (!in_bits[g]) begin
            shot_reg <= 1'b0;
          end else if (rise) begin
            shot_reg <= 1'b1;
            shot_cnt_reg <= chopper_ctrl_reg.first_pulse_width;
          end else if (shot_reg && base_tick) begin
            if (shot_cnt_reg == 4'h0) shot_reg <= 1'b0;
            else shot_cnt_reg <= shot_cnt_reg - 4'h1;
          end
        end
      end
      // pulse covers the rising cycle itself, then the counted ticks
      assign chopped[g] = in_bits[g] & (rise | shot_reg | carrier);
      assign out_next[g] = chopper_ctrl_reg.chopping_on ? chopped[g] : in_bits[g];
    end
  endgenerate

  // registered outputs: one cycle latency in both modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out_a <= 1'b0;
    end else begin
      pwm_out_a <= out_next[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out_b <= 1'b0;
    end else begin
      pwm_out_b <= out_next[0];
    end
  end

endmodule

// ---- test/chopper_assertions.sv ----
`timescale 1ns/1ps
module chopper_assertions
  import chopper_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire pwm_pair_t qual_in,
  input wire pwm_pair_t deadband_in,
  input wire logic [DELAY_W-1:0] rise_delay_count,
  input wire logic [DELAY_W-1:0] fall_delay_count,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  chk_rise_load: assert property (wr && paddr == 12'h000 |=>
    rise_delay_count == $past(pwdata[9:0])) else $error("rise load");
  chk_rise_hold: assert property (!(wr && paddr == 12'h000) |=>
    $stable(rise_delay_count)) else $error("rise changed");
  chk_fall_load: assert property (wr && paddr == 12'h004 |=>
    fall_delay_count == $past(pwdata[9:0])) else $error("fall load");
  chk_rise_upper: assert property (rd && paddr == 12'h000 |->
    prdata[31:10] == 0) else $error("rise upper");
  chk_fall_upper: assert property (rd && paddr == 12'h004 |->
    prdata[31:10] == 0) else $error("fall upper");
  chk_ctrl_upper: assert property (rd && paddr == 12'h008 |->
    prdata[31:11] == 0) else $error("ctrl upper");
  chk_a_low: assert property (!qual_in.a && !deadband_in.a |=>
    !pwm_out_a) else $error("a high");
  chk_b_low: assert property (!qual_in.b && !deadband_in.b |=>
    !pwm_out_b) else $error("b high");
endmodule
bind pwm_chopper chopper_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .qual_in, .deadband_in, .rise_delay_count,
  .fall_delay_count, .pwm_out_a, .pwm_out_b);

// ---- test/gate_driver_model.sv ----
`timescale 1ns/1ps
module gate_driver_model (
  input wire logic pclk,
  input wire logic clr,
  input wire logic gate,
  output int hi_cnt,
  output int rise_cnt
);
  logic last;
  // a gate stage only sees on-time and switching events
  always_ff @(posedge pclk) begin
    last <= gate;
    hi_cnt <= clr ? 0 : hi_cnt + int'(gate);
    rise_cnt <= clr ? 0 : rise_cnt + int'(gate && !last);
  end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import chopper_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_out_a, pwm_out_b, clr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic err_seen;
  pwm_pair_t qual_in, deadband_in;
  logic [DELAY_W-1:0] rise_delay_count, fall_delay_count;
  int n_mismatch, tests_run, hi_a, rise_a, hi_b, rise_b, n_exp;
  pwm_chopper u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .qual_in, .deadband_in, .rise_delay_count, .fall_delay_count,
    .pwm_out_a, .pwm_out_b);
  gate_driver_model u_drv_a (.pclk, .clr, .gate(pwm_out_a), .hi_cnt(hi_a), .rise_cnt(rise_a));
  gate_driver_model u_drv_b (.pclk, .clr, .gate(pwm_out_b), .hi_cnt(hi_b), .rise_cnt(rise_b));
  task wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, s, e);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1 && i < 50);
    r = prdata;
    err_seen = pslverr;
    psel <= 0;
    penable <= 0;
    if (i == 50) begin
      n_mismatch++;
      wrap_up;
    end
    @(posedge pclk);
  endtask
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, qual_in, deadband_in} = '0;
    clr = 1;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int k = 0; k < 3; k++) begin
      xfer(0, 12'(4 * k), 0);
      chk(r, 0);
      xfer(1, 12'(4 * k), 32'hFFFFFFFF);
      xfer(0, 12'(4 * k), 0);
      chk(r, k == 2 ? 32'h7FF : 32'h3FF);
    end
    chk(32'(err_seen), 0);
    chk(32'({rise_delay_count, fall_delay_count}), 32'hFFFFF);
    xfer(0, 12'h010, 0);
    chk(r, 0);
    chk(32'(err_seen), 1);
    xfer(1, 12'h008, 0);
    qual_in <= '1;
    repeat (3) @(posedge pclk);
    chk(32'({pwm_out_a, pwm_out_b}), 32'h3);
    xfer(1, 12'h00C, 3);
    @(posedge pclk);
    chk(32'({pwm_out_a, pwm_out_b}), 32'h0);
    qual_in <= '0;
    xfer(1, 12'h00C, 0);
    // duty code 7 leaves the carrier low, so only the first pulse shows
    for (int w = 0; w < 16; w += 15) begin
      xfer(1, 12'h008, 32'h701 | 32'(w << 1));
      {clr, qual_in} <= 3;
      repeat (200) @(posedge pclk);
      qual_in <= '0;
      repeat (3) @(posedge pclk);
      chk(32'(hi_a >= 8 * w + 2 && hi_a <= 8 * w + 9), 1);
      clr <= 1;
    end
    for (int f = 0; f < 8; f = 2 * f + 1) begin
      xfer(1, 12'h008, 32'h301 | 32'(f << 5));
      {clr, qual_in} <= 3;
      repeat (1024) @(posedge pclk);
      qual_in <= '0;
      repeat (3) @(posedge pclk);
      chk(32'(hi_a > 456 && hi_a < 576), 1);
      n_exp = 1024 / (BASE_DIV * (f + 1));
      chk(32'(rise_b >= n_exp - 2 && rise_b <= n_exp + 2), 1);
      clr <= 1;
    end
    wrap_up;
  end
endmodule
